/* File: src/mpp_pkg.sv */
// Constants, register map and carrier types of the port pin block.
// How it works
// - Per-bit direction; port zero bits 0,7 input-only.
// - Pull-up acts only on input-direction bits.
// - Analog mode forces port 1 pull-ups off.
// - Ports 8, 9 pick segment output per pair.
// - Port 11 falling edges set sticky flags.
package mpp_pkg;

  localparam int NPORT = 9;
  localparam int PW = 8;

  typedef logic [PW-1:0] mpp_byte_t;

  typedef struct packed {
    mpp_byte_t dout;
    mpp_byte_t oe_n;
    mpp_byte_t pull;
  } mpp_pad_t;

  typedef mpp_pad_t [NPORT-1:0] mpp_pad_vec_t;
  typedef mpp_byte_t [NPORT-1:0] mpp_byte_vec_t;

  // Port numbers held by each instance slot, slot 0 rightmost.
  localparam logic [NPORT-1:0][3:0] PORT_ID = {
    4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h3, 4'h2, 4'h1, 4'h0
  };
  // Implemented bits of each port.
  localparam mpp_byte_vec_t PORT_MASK = {
    8'hff, 8'h0f, 8'hff, 8'hff, 8'h07, 8'hff, 8'he0, 8'hff, 8'hbf
  };
  // Bits that can never be outputs.
  localparam mpp_byte_vec_t INPUT_ONLY_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81
  };

  localparam int SLOT_P1 = 1;
  localparam int SLOT_P8 = 5;
  localparam int SLOT_P9 = 6;
  localparam int SLOT_P11 = 8;

  localparam int AW = 9;
  // Port p occupies a 16-byte slot at p times 0x10.
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_DIR = 4'h4;
  localparam logic [3:0] OFS_PULL = 4'h8;
  localparam logic [AW-1:0] ADDR_GLOBAL = 9'h100;
  localparam logic [AW-1:0] ADDR_DISPLAY_CTRL = 9'h100;
  localparam logic [AW-1:0] ADDR_CLOCK_CTRL = 9'h104;
  localparam logic [AW-1:0] ADDR_ANALOG_CTRL = 9'h108;
  localparam logic [AW-1:0] ADDR_IRQ_STATUS = 9'h110;
  localparam logic [AW-1:0] ADDR_IRQ_CLEAR = 9'h114;
  localparam logic [AW-1:0] ADDR_IRQ_ENABLE = 9'h118;

  localparam int FRO_BIT = 6;
  localparam int ANALOG_MODE_BIT = 0;
  localparam int P8_PAIR_LSB = 0;
  localparam int P9_PAIR_LSB = 4;

  localparam mpp_byte_t DIR_RESET = 8'hff;
  localparam mpp_byte_t DATA_RESET = 8'h00;
  localparam mpp_byte_t PULL_RESET = 8'h00;
  localparam mpp_byte_t CTRL_RESET = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

/* File: src/mpp_sync.sv */
// Three-stage pin synchroniser with an agreement filter.
`timescale 1ns/1ps
module mpp_sync #(
  parameter int W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] level_nxt;

  // A bit changes only once the second and third stages agree.
  assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
  assign level_o = level_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end
endmodule

/* File: src/mpp_port.sv */
// One port: output latch, direction, pull-up enable and pad drive.
`timescale 1ns/1ps
module mpp_port
  import mpp_pkg::*;
#(
  parameter mpp_pkg::mpp_byte_t VALID = 8'hff,
  parameter mpp_pkg::mpp_byte_t IN_ONLY = 8'h00
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic we_data,
  input wire logic we_dir,
  input wire logic we_pull,
  input wire mpp_pkg::mpp_byte_t wdata,
  input wire mpp_pkg::mpp_byte_t level,
  input wire mpp_pkg::mpp_byte_t seg_sel,
  input wire mpp_pkg::mpp_byte_t seg_val,
  input wire logic pull_block,
  output mpp_pkg::mpp_byte_t rd_data,
  output mpp_pkg::mpp_byte_t rd_dir,
  output mpp_pkg::mpp_byte_t rd_pull,
  output mpp_pkg::mpp_pad_t pad
);
  mpp_byte_t data_r;
  mpp_byte_t dir_r;
  mpp_byte_t pull_r;
  mpp_byte_t is_in;
  mpp_byte_t drive;

  assign is_in = (dir_r | IN_ONLY) & VALID;
  assign drive = ((~is_in & VALID) | (seg_sel & VALID)) & ~IN_ONLY;
  assign pad.dout = ((seg_sel & seg_val) | (~seg_sel & data_r)) & drive;
  assign pad.oe_n = ~drive;
  assign pad.pull = pull_r & is_in & ~seg_sel & {PW{~pull_block}};
  assign rd_data = ((is_in & level) | (~is_in & data_r)) & VALID;
  assign rd_dir = is_in;
  assign rd_pull = pull_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= DATA_RESET;
      dir_r <= DIR_RESET;
      pull_r <= PULL_RESET;
    end else begin
      if (we_data) begin
        data_r <= wdata & VALID;
      end
      if (we_dir) begin
        dir_r <= (wdata | IN_ONLY) & VALID;
      end
      if (we_pull) begin
        pull_r <= wdata & VALID;
      end
    end
  end
endmodule

/* File: src/mpp_top.sv */
// Port pin block top: AHB-Lite slave, ports, segment sharing and edge flags.
`timescale 1ns/1ps
module mpp_top
  import mpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire mpp_pkg::mpp_byte_vec_t pin_in,
  output mpp_pkg::mpp_pad_vec_t pad_o,
  output mpp_pkg::mpp_byte_vec_t pin_level_o,
  input wire mpp_pkg::mpp_byte_t segment_out_upper,
  input wire mpp_pkg::mpp_byte_t segment_out_lower,
  output logic feedback_resistor_off,
  output logic analog_in_mode,
  output logic irq
);
  import mpp_pkg::*;

  logic ap_take;
  logic ap_wr_r;
  logic rd_pend_r;
  logic [AW-1:0] ap_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic wr_act;
  logic [AW-1:0] wa;
  mpp_byte_t wbyte;
  logic ap_sel;
  logic ap_nonseq;
  logic glb_sel;
  logic [AW-5:0] slot_addr;
  logic [3:0] reg_ofs;
  logic off_data;
  logic off_dir;
  logic off_pull;

  mpp_byte_t display_ctrl_reg_r;
  mpp_byte_t processor_clock_ctrl_r;
  mpp_byte_t analog_ctrl_r;
  mpp_byte_t irq_status_r;
  mpp_byte_t irq_status_nxt;
  mpp_byte_t irq_enable_r;
  mpp_byte_t edge_prev_r;
  mpp_byte_t fall_evt;
  mpp_byte_t irq_clear;

  mpp_byte_vec_t level;
  mpp_byte_vec_t rd_data;
  mpp_byte_vec_t rd_dir;
  mpp_byte_vec_t rd_pull;
  mpp_byte_vec_t seg_sel;
  mpp_byte_vec_t seg_val;
  logic [NPORT-1:0] we_data;
  logic [NPORT-1:0] we_dir;
  logic [NPORT-1:0] we_pull;
  logic [NPORT-1:0] rd_hit;
  mpp_byte_vec_t rd_slot;

  mpp_byte_t p8_seg;
  mpp_byte_t p9_seg;
  mpp_byte_t upper_rev;
  mpp_byte_t lower_rev;
  logic [3:0] p8_pairs;
  logic [3:0] p9_pairs;

  logic glb_hit_disp;
  logic glb_hit_clk;
  logic glb_hit_ana;
  logic glb_hit_ist;
  logic glb_hit_ien;
  logic glb_hit_icl;

  logic we_disp;
  logic we_clk;
  logic we_ana;
  logic we_ien;
  logic we_icl;
  mpp_byte_t irq_keep;
  mpp_byte_t irq_pend;

  // Address phase is taken on a selected NONSEQ with the bus ready.
  assign ap_sel = hsel & hready;
  assign ap_nonseq = (htrans == HTRANS_NONSEQ);
  assign ap_take = ap_sel & ap_nonseq;
  assign wr_act = ap_wr_r;
  assign wa = ap_addr_r;
  assign wbyte = hwdata[PW-1:0];

  // Port registers sit below the global block; the low nibble picks the register.
  assign glb_sel = wa[AW-1];
  assign slot_addr = wa[AW-1:4];
  assign reg_ofs = wa[3:0];
  assign off_data = (reg_ofs == OFS_DATA);
  assign off_dir = (reg_ofs == OFS_DIR);
  assign off_pull = (reg_ofs == OFS_PULL);

  // Reads insert one wait state so the data reflects any earlier write.
  assign hreadyout = ~rd_pend_r;
  assign hrdata = hrdata_r;
  assign hresp = HRESP_OKAY;

  // The data phase acts on the direction and address captured here.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
    end else begin
      ap_wr_r <= ap_take & hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= ap_take & ~hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_addr_r <= '0;
    end else if (ap_take) begin
      ap_addr_r <= haddr[AW-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  // Pin inputs cross into the clock domain through the synchroniser.
  mpp_sync #(
    .W(NPORT * PW)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_i(pin_in),
    .level_o(level)
  );

  assign pin_level_o = level;

  // Per-slot decode of the three port registers.
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      logic slot_hit;
      logic pull_blk;
      assign slot_hit = (slot_addr == {1'b0, PORT_ID[g]});
      assign pull_blk = (g == SLOT_P1) ? analog_in_mode : 1'b0;
      assign we_data[g] = wr_act & slot_hit & off_data;
      assign we_dir[g] = wr_act & slot_hit & off_dir;
      assign we_pull[g] = wr_act & slot_hit & off_pull;
      assign rd_hit[g] = slot_hit;
      assign rd_slot[g] = ~rd_hit[g] ? 8'h00 :
                          off_data ? rd_data[g] :
                          off_dir ? rd_dir[g] :
                          off_pull ? rd_pull[g] : 8'h00;
      assign seg_sel[g] = (g == SLOT_P8) ? p8_seg :
                          (g == SLOT_P9) ? p9_seg : 8'h00;
      assign seg_val[g] = (g == SLOT_P8) ? upper_rev :
                          (g == SLOT_P9) ? lower_rev : 8'h00;

      mpp_port #(
        .VALID(PORT_MASK[g]),
        .IN_ONLY(INPUT_ONLY_MASK[g])
      ) u_port (
        .hclk(hclk),
        .hresetn(hresetn),
        .we_data(we_data[g]),
        .we_dir(we_dir[g]),
        .we_pull(we_pull[g]),
        .wdata(wbyte),
        .level(level[g]),
        .seg_sel(seg_sel[g]),
        .seg_val(seg_val[g]),
        .pull_block(pull_blk),
        .rd_data(rd_data[g]),
        .rd_dir(rd_dir[g]),
        .rd_pull(rd_pull[g]),
        .pad(pad_o[g])
      );
    end
  endgenerate

  // Segment lines run in reverse order across ports 8 and 9.
  assign upper_rev = {<<{segment_out_upper}};
  assign lower_rev = {<<{segment_out_lower}};
  assign p8_pairs = display_ctrl_reg_r[P8_PAIR_LSB +: 4];
  assign p9_pairs = display_ctrl_reg_r[P9_PAIR_LSB +: 4];
  assign p8_seg = {p8_pairs[3], p8_pairs[3], p8_pairs[2], p8_pairs[2],
                   p8_pairs[1], p8_pairs[1], p8_pairs[0], p8_pairs[0]};
  assign p9_seg = {p9_pairs[3], p9_pairs[3], p9_pairs[2], p9_pairs[2],
                   p9_pairs[1], p9_pairs[1], p9_pairs[0], p9_pairs[0]};

  // Global register decode.
  assign glb_hit_disp = (wa == ADDR_DISPLAY_CTRL);
  assign glb_hit_clk = (wa == ADDR_CLOCK_CTRL);
  assign glb_hit_ana = (wa == ADDR_ANALOG_CTRL);
  assign glb_hit_ist = (wa == ADDR_IRQ_STATUS);
  assign glb_hit_ien = (wa == ADDR_IRQ_ENABLE);
  assign glb_hit_icl = (wa == ADDR_IRQ_CLEAR);
  assign we_disp = wr_act & glb_hit_disp;
  assign we_clk = wr_act & glb_hit_clk;
  assign we_ana = wr_act & glb_hit_ana;
  assign we_ien = wr_act & glb_hit_ien;
  assign we_icl = wr_act & glb_hit_icl;

  assign feedback_resistor_off = processor_clock_ctrl_r[FRO_BIT];
  assign analog_in_mode = analog_ctrl_r[ANALOG_MODE_BIT];

  // Each control register keeps its value until software writes it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      display_ctrl_reg_r <= CTRL_RESET;
    end else if (we_disp) begin
      display_ctrl_reg_r <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      processor_clock_ctrl_r <= CTRL_RESET;
    end else if (we_clk) begin
      processor_clock_ctrl_r <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_ctrl_r <= CTRL_RESET;
    end else if (we_ana) begin
      analog_ctrl_r <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_r <= CTRL_RESET;
    end else if (we_ien) begin
      irq_enable_r <= wbyte;
    end
  end

  // Falling edges of port 11 set sticky flags; a new edge beats a clear.
  assign fall_evt = edge_prev_r & ~level[SLOT_P11];
  assign irq_clear = we_icl ? wbyte : 8'h00;
  assign irq_keep = irq_status_r & ~irq_clear;
  assign irq_status_nxt = irq_keep | fall_evt;
  // The interrupt line is high while any enabled flag is set.
  assign irq_pend = irq_status_r & irq_enable_r;
  assign irq = |irq_pend;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_prev_r <= 8'h00;
    end else begin
      edge_prev_r <= level[SLOT_P11];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= 8'h00;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // Read multiplexer; unmapped and write-only addresses read as zero.
  mpp_byte_t port_rd;
  mpp_byte_t glb_rd;
  always_comb begin
    port_rd = 8'h00;
    for (int i = 0; i < NPORT; i++) begin
      port_rd = port_rd | rd_slot[i];
    end
  end

  assign glb_rd = glb_hit_disp ? display_ctrl_reg_r :
                  glb_hit_clk ? processor_clock_ctrl_r :
                  glb_hit_ana ? analog_ctrl_r :
                  glb_hit_ist ? irq_status_r :
                  glb_hit_ien ? irq_enable_r : 8'h00;
  assign rd_mux = {24'h000000, (glb_sel ? glb_rd : port_rd)};

  logic unused_ok;
  assign unused_ok = &{1'b0, haddr[31:AW], hsize, hwdata[31:PW], ADDR_GLOBAL[0]};
endmodule

/* File: tb/mpp_board.sv */
// Board model that resolves each port pin from pad drive, pull-up or an outside source.
`timescale 1ns/1ps
module mpp_board
  import mpp_pkg::*;
(
  input wire mpp_pkg::mpp_pad_vec_t pad_o,
  input wire mpp_pkg::mpp_byte_vec_t ext,
  output mpp_pkg::mpp_byte_vec_t pin_in
);
  always_comb begin
    for (int s = 0; s < NPORT; s++) begin
      for (int b = 0; b < PW; b++) begin
        if (!pad_o[s].oe_n[b]) pin_in[s][b] = pad_o[s].dout[b];
        else if (pad_o[s].pull[b]) pin_in[s][b] = 1'b1;
        else pin_in[s][b] = ext[s][b];
      end
    end
  end
endmodule

/* File: tb/mpp_top_assertions.sv */
// Checker of the port pin block top-level ports.
`timescale 1ns/1ps
module mpp_top_chk
  import mpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire mpp_pkg::mpp_byte_vec_t pin_in,
  input wire mpp_pkg::mpp_pad_vec_t pad_o,
  input wire mpp_pkg::mpp_byte_vec_t pin_level_o,
  input wire mpp_pkg::mpp_byte_t segment_out_upper,
  input wire mpp_pkg::mpp_byte_t segment_out_lower,
  input wire logic feedback_resistor_off,
  input wire logic analog_in_mode,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic req = hsel && hready && htrans == HTRANS_NONSEQ;
  a_port0_input_only: assert property (pad_o[0].oe_n[0] && pad_o[0].oe_n[7])
    else $error("port zero input-only bit driven");
  a_pull_input_only: assert property ((pad_o[3].pull & ~pad_o[3].oe_n) == 8'h00)
    else $error("pull-up on an output bit");
  a_segment_pull_off: assert property ((pad_o[SLOT_P8].pull & ~pad_o[SLOT_P8].oe_n) == 8'h00)
    else $error("pull-up on a driven segment bit");
  a_analog_pull_off: assert property (analog_in_mode |-> pad_o[SLOT_P1].pull == 8'h00)
    else $error("port 1 pull-up in analog mode");
  a_reset_all_inputs: assert property (@(posedge hclk) disable iff (1'b0)
    !hresetn |-> pad_o[SLOT_P8].oe_n == 8'hff && !irq)
    else $error("pin driven during reset");
  a_read_one_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (req && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_always_okay: assert property (hresp == HRESP_OKAY)
    else $error("error response");
  a_fall_after_low: assert property ($fell(pin_level_o[SLOT_P11][0])
    |-> !$past(pin_in[SLOT_P11][0], 3))
    else $error("level fell without low pin");
  cover property (req && !hwrite);
  cover property ($rose(irq));
  cover property (analog_in_mode && pad_o[SLOT_P1].oe_n == 8'hff);
endmodule

bind mpp_top mpp_top_chk mpp_top_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in),
  .pad_o(pad_o), .pin_level_o(pin_level_o), .segment_out_upper(segment_out_upper),
  .segment_out_lower(segment_out_lower), .feedback_resistor_off(feedback_resistor_off),
  .analog_in_mode(analog_in_mode), .irq(irq));

/* File: tb/testbench.sv */
// Testbench of the port pin block: registers, pads, segments and edge flags.
`timescale 1ns/1ps
module testbench;
  import mpp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, fro, ana;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  mpp_byte_vec_t pin_in, pin_lvl, ext;
  mpp_pad_vec_t pad_o;
  mpp_byte_t seg_up, seg_lo;
  int fail_count = 0;
  int compares = 0;
  localparam logic [31:0] RA [8] = '{'h004, 'h024, 'h074, 'h0a8, 'h104, 'h00c, 'h118, 'h114};
  localparam logic [31:0] RW [8] = '{'h00, 'h00, 'hfa, 'hff, 'h40, 'h55, 'h5a, 'hff};
  localparam logic [31:0] RE [8] = '{'h81, 'h00, 'h02, 'h0f, 'h40, 'h00, 'h5a, 'h00};

  mpp_top mpp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in), .pad_o(pad_o),
    .pin_level_o(pin_lvl), .segment_out_upper(seg_up), .segment_out_lower(seg_lo),
    .feedback_resistor_off(fro), .analog_in_mode(ana), .irq(irq));
  mpp_board mpp_board_inst (.pad_o(pad_o), .ext(ext), .pin_in(pin_in));

  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(negedge hclk);
  endtask

  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    test_done();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, seg_up, seg_lo} = '0;
    hresetn = 1'b1;
    hsize = 3'h2;
    ext = '0;
    ext[SLOT_P11] = 8'hff;
    ext[0] = 8'h80;
    #1 hresetn = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    xfer(0, 'h014, 0);
    chk(q, 'hff);
    xfer(0, 'h100, 0);
    chk(q, 'h00);
    chk(pad_o[SLOT_P8].oe_n, 'hff);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      xfer(1, RA[i], RW[i]);
      xfer(0, RA[i], 0);
      chk(q, RE[i]);
    end
    chk(fro, 1);
    $display("register rows done");
    xfer(1, 'h034, 'h0f);
    xfer(1, 'h030, 'ha5);
    xfer(1, 'h038, 'hff);
    chk(pad_o[3].oe_n, 'h0f);
    chk(pad_o[3].pull, 'h0f);
    repeat (6) @(posedge hclk);
    xfer(0, 'h030, 0);
    chk(q, 'haf);
    xfer(0, 'h000, 0);
    chk(q, 'h80);
    $display("pad test done");
    xfer(1, 'h014, 'hff);
    xfer(1, 'h018, 'hff);
    chk(pad_o[SLOT_P1].pull, 'hff);
    xfer(1, 'h108, 'h01);
    chk(pad_o[SLOT_P1].pull, 'h00);
    chk(ana, 1);
    xfer(1, 'h108, 'h00);
    chk(pad_o[SLOT_P1].pull, 'hff);
    $display("analog test done");
    @(posedge hclk);
    seg_up <= 8'h80;
    seg_lo <= 8'h10;
    xfer(1, 'h088, 'hff);
    xfer(1, 'h100, 'h21);
    chk(pad_o[SLOT_P8].oe_n, 'hfc);
    chk(pad_o[SLOT_P8].dout[1:0], 'h1);
    chk(pad_o[SLOT_P8].pull, 'hfc);
    chk(pad_o[SLOT_P9].oe_n, 'hf3);
    chk(pad_o[SLOT_P9].dout[3:2], 'h2);
    $display("segment test done");
    xfer(1, 'h118, 'h01);
    @(posedge hclk);
    ext[SLOT_P11] <= 8'hfc;
    repeat (8) @(posedge hclk);
    xfer(0, 'h110, 0);
    chk(q, 'h03);
    chk(irq, 1);
    chk(pin_lvl[SLOT_P11], 'hfc);
    xfer(1, 'h114, 'h01);
    xfer(0, 'h110, 0);
    chk(q, 'h02);
    chk(irq, 0);
    xfer(1, 'h118, 'h02);
    chk(irq, 1);
    xfer(1, 'h114, 'h02);
    chk(irq, 0);
    $display("edge flag test done");
    @(posedge hclk);
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk(pad_o[3].oe_n, 'hff);
    chk(irq, 0);
    @(posedge hclk);
    hresetn <= 1;
    xfer(0, 'h034, 0);
    chk(q, 'hff);
    $display("mid-run reset done");
    test_done();
  end
endmodule
